// *** logic/asrc_ctrl.sv ***
`timescale 1ns/1ns
`include "asrc_consts.svh"
// How it works
// - Host holds write address stable long enough before the write ends.
// - Host sets address no later than write start.
// - Host keeps address unchanged until the write ends.
// - Host holds chosen byte enables low long enough before write end.
// - Host drives write data long enough before write end, until the end.
// - Write needs strobe, both selects, a byte enable; any one ends it.
// - Host times data setup and hold against the signal ending the write.
// - Strobe-ended write with outputs enabled lasts setup plus release time.
module asrc_ctrl
    import asrc_pkg::*;
#(
    parameter bit SLOW_GRADE = 1'b0
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Request port
    input wire logic i_req_valid,
    input wire asrc_req_type i_req,
    output logic o_req_ready,
    // Answer port
    output logic o_rsp_valid,
    output asrc_rsp_type o_rsp,
    // Memory pins
    output asrc_pins_type o_pins,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data,
    output logic [15:0] o_data_oe,
    input wire logic i_corrected
);
    // ----------------------------------------
    // Timing counts for the chosen grade
    // ----------------------------------------
    localparam logic [3:0] RD_CYC = SLOW_GRADE ? 4'(`ASRC_RD_CYC_SLOW) : 4'(`ASRC_RD_CYC_FAST);
    localparam logic [3:0] WR_CYC = SLOW_GRADE ? 4'(`ASRC_WR_CYC_SLOW) : 4'(`ASRC_WR_CYC_FAST);
    localparam logic [3:0] RC_CYC = SLOW_GRADE ? 4'(`ASRC_RC_CYC_SLOW) : 4'(`ASRC_RC_CYC_FAST);
    localparam logic [3:0] TURN_CYC = 4'(`ASRC_TURN_CYC);
    localparam logic [3:0] REC_CYC = 4'(`ASRC_REC_CYC);
    // Edges from take to the sampled answer pulse, for the checks below
    localparam int RD_LAT = SLOW_GRADE ? `ASRC_RD_CYC_SLOW + 1 : `ASRC_RD_CYC_FAST + 1;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_READ = 5'h02,
        ST_TURN = 5'h04,
        ST_WRITE = 5'h08,
        ST_REC = 5'h10
    } asrc_state_type;

    // ----------------------------------------
    // Synchronised pin inputs
    // ----------------------------------------
    logic [16:0] pin_in_s;
    asrc_sync #(.W(17)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d({i_corrected, i_data}),
        .o_q(pin_in_s)
    );

    // Idle pin state: deselected, all strobes inactive
    function automatic asrc_pins_type idle_pins(input logic [17:0] a);
        asrc_pins_type p;
        p = '{a, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        return p;
    endfunction

    asrc_state_type state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [3:0] gap_r, gap_nxt;
    asrc_req_type req_r, req_nxt;
    asrc_pins_type pins_r, pins_nxt;
    logic [15:0] dout_r, dout_nxt;
    logic [15:0] oe_r, oe_nxt;
    logic rdy_r, rdy_nxt;
    logic rv_r, rv_nxt;
    asrc_rsp_type rsp_r, rsp_nxt;

    // ----------------------------------------
    // Cycle sequencer next state
    // ----------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        gap_nxt = (gap_r != 4'h0) ? gap_r - 4'h1 : 4'h0;
        req_nxt = req_r;
        pins_nxt = pins_r;
        dout_nxt = dout_r;
        oe_nxt = oe_r;
        rdy_nxt = 1'b0;
        rv_nxt = 1'b0;
        rsp_nxt = rsp_r;
        case (state_r)
            ST_IDLE:
            begin
                rdy_nxt = (gap_nxt == 4'h0);
                if (i_req_valid && rdy_r)
                begin
                    req_nxt = i_req;
                    cnt_nxt = 4'h0;
                    gap_nxt = RC_CYC;
                    rdy_nxt = 1'b0;
                    // Address and both selects together
                    pins_nxt.addr = i_req.addr;
                    pins_nxt.select_primary_n = 1'b0;
                    pins_nxt.select_secondary_hi = 1'b1;
                    pins_nxt.upper_byte_en_n = ~i_req.byte_en[1];
                    pins_nxt.lower_byte_en_n = ~i_req.byte_en[0];
                    if (i_req.write)
                    begin
                        // Outputs stay disabled so the strobe alone sets width
                        pins_nxt.write_en_n = 1'b0;
                        dout_nxt = i_req.wdata;
                        oe_nxt = {{8{i_req.byte_en[1]}}, {8{i_req.byte_en[0]}}};
                        state_nxt = ST_WRITE;
                    end
                    else
                    begin
                        pins_nxt.out_en_n = 1'b0;
                        state_nxt = ST_READ;
                    end
                end
            end
            ST_READ:
            begin
                cnt_nxt = cnt_r + 4'h1;
                // Sample after address, select and enable access times
                if (cnt_r == RD_CYC - 4'h1)
                begin
                    rv_nxt = 1'b1;
                    rsp_nxt.rdata = pin_in_s[15:0];
                    rsp_nxt.corrected = pin_in_s[16];
                    // Address held while data is sampled
                    pins_nxt = idle_pins(req_r.addr);
                    cnt_nxt = 4'h0;
                    state_nxt = ST_TURN;
                end
            end
            ST_TURN:
            begin
                // Wait for the memory to release the bus
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == TURN_CYC - 4'h1)
                begin
                    cnt_nxt = 4'h0;
                    state_nxt = ST_IDLE;
                end
            end
            ST_WRITE:
            begin
                cnt_nxt = cnt_r + 4'h1;
                // Strobe width covers address, byte and data setup
                if (cnt_r == WR_CYC - 4'h1)
                begin
                    // Strobe ends the write; address and data held this edge
                    pins_nxt.write_en_n = 1'b1;
                    cnt_nxt = 4'h0;
                    state_nxt = ST_REC;
                end
            end
            ST_REC:
            begin
                // Zero hold: release data and deselect, then allow recovery
                pins_nxt = idle_pins(req_r.addr);
                oe_nxt = 16'h0000;
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == REC_CYC - 4'h1)
                begin
                    cnt_nxt = 4'h0;
                    state_nxt = ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
                pins_nxt = idle_pins(18'h00000);
                oe_nxt = 16'h0000;
            end
        endcase
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            gap_r <= 4'h0;
            req_r <= '0;
            pins_r <= '{18'h00000, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
            dout_r <= 16'h0000;
            oe_r <= 16'h0000;
            rdy_r <= 1'b0;
            rv_r <= 1'b0;
            rsp_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            gap_r <= gap_nxt;
            req_r <= req_nxt;
            pins_r <= pins_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            rdy_r <= rdy_nxt;
            rv_r <= rv_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    assign o_pins = pins_r;
    assign o_data = dout_r;
    assign o_data_oe = oe_r;
    assign o_req_ready = rdy_r;
    assign o_rsp_valid = rv_r;
    assign o_rsp = rsp_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_wr_start;
        state_r == ST_IDLE && i_req_valid && rdy_r && i_req.write;
    endsequence

    a_write_strobe_width: assert property (s_wr_start |=> !pins_r.write_en_n [*6])
        else $error("write strobe too short");
    a_write_addr_hold: assert property (!pins_r.write_en_n |=> $stable(pins_r.addr))
        else $error("address moved during write");
    a_write_data_hold: assert property (!pins_r.write_en_n |=> $stable(o_data))
        else $error("write data moved before write end");
    a_write_full_sel: assert property (!pins_r.write_en_n |-> !pins_r.select_primary_n
        && pins_r.select_secondary_hi && pins_r.out_en_n)
        else $error("write strobe without selection");
    a_read_no_drive: assert property (!pins_r.out_en_n |-> o_data_oe == 16'h0000)
        else $error("host drives data during read");
    a_read_sample_time: assert property (state_r == ST_IDLE && i_req_valid && rdy_r
        && !i_req.write |-> ##RD_LAT o_rsp_valid)
        else $error("read answer at wrong time");
    // A new cycle only opens once the spacing count has run out, and reloads it
    a_cycle_spacing: assert property ($fell(pins_r.select_primary_n)
        |-> $past(gap_r) == 4'h0 && gap_r == RC_CYC)
        else $error("cycle spacing violated");
    a_turn_before_drive: assert property ($fell(pins_r.out_en_n == 1'b0)
        |-> o_data_oe == 16'h0000 [*3])
        else $error("bus driven during turnaround");
endmodule

// *** logic/asrc_consts.svh ***
`ifndef ASRC_CONSTS_SVH
`define ASRC_CONSTS_SVH
// ----------------------------------------
// Clock
// ----------------------------------------
`define ASRC_CLK_PERIOD_NS 8
// ----------------------------------------
// Speed-grade timing in ns (fast / slow)
// ----------------------------------------
`define ASRC_T_AA_FAST_NS 45
`define ASRC_T_AA_SLOW_NS 55
`define ASRC_T_DOE_FAST_NS 22
`define ASRC_T_DOE_SLOW_NS 25
`define ASRC_T_DBE_FAST_NS 22
`define ASRC_T_DBE_SLOW_NS 25
`define ASRC_T_OHA_NS 10
`define ASRC_T_HZ_NS 18
`define ASRC_T_HZWE_FAST_NS 18
`define ASRC_T_HZWE_SLOW_NS 20
`define ASRC_T_LZWE_NS 10
`define ASRC_T_AW_FAST_NS 35
`define ASRC_T_AW_SLOW_NS 45
`define ASRC_T_SD_NS 25
`define ASRC_T_RC_FAST_NS 45
`define ASRC_T_RC_SLOW_NS 55
// ----------------------------------------
// Cycle counts: least and longest times all round up; ASRC_CYC_DN is not used
// ----------------------------------------
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CYC_DN(ns) (((ns) / `ASRC_CLK_PERIOD_NS) < 1 ? 1 : ((ns) / `ASRC_CLK_PERIOD_NS))
// Read sample delay covers the slowest of address, select, enable to valid
`define ASRC_RD_CYC_FAST (`ASRC_CYC_UP(`ASRC_T_AA_FAST_NS) + 2)
`define ASRC_RD_CYC_SLOW (`ASRC_CYC_UP(`ASRC_T_AA_SLOW_NS) + 2)
// Write strobe width: data setup plus release time
`define ASRC_WR_CYC_FAST `ASRC_CYC_UP(`ASRC_T_SD_NS + `ASRC_T_HZWE_FAST_NS)
`define ASRC_WR_CYC_SLOW `ASRC_CYC_UP(`ASRC_T_SD_NS + `ASRC_T_HZWE_SLOW_NS)
// Bus turnaround after a read before the host drives data
`define ASRC_TURN_CYC `ASRC_CYC_UP(`ASRC_T_HZ_NS)
// Recovery after a write before outputs may be enabled again
`define ASRC_REC_CYC `ASRC_CYC_UP(`ASRC_T_LZWE_NS)
// Least cycle time
`define ASRC_RC_CYC_FAST `ASRC_CYC_UP(`ASRC_T_RC_FAST_NS)
`define ASRC_RC_CYC_SLOW `ASRC_CYC_UP(`ASRC_T_RC_SLOW_NS)
`endif

// *** logic/asrc_pkg.sv ***
package asrc_pkg;
    // ----------------------------------------
    // Pin group, request and answer types
    // ----------------------------------------
    typedef struct packed {
        logic [17:0] addr;
        logic select_primary_n;
        logic select_secondary_hi;
        logic write_en_n;
        logic out_en_n;
        logic upper_byte_en_n;
        logic lower_byte_en_n;
    } asrc_pins_type;

    typedef struct packed {
        logic write;
        logic [1:0] byte_en;
        logic [17:0] addr;
        logic [15:0] wdata;
    } asrc_req_type;

    typedef struct packed {
        logic [15:0] rdata;
        logic corrected;
    } asrc_rsp_type;
endpackage

// *** logic/asrc_sync.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser for pin inputs
module asrc_sync
    import asrc_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // Next values
    always_comb
    begin
        meta_nxt = i_d;
        q_nxt = meta_r;
    end

    // Register stages
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_r <= '0;
            q_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign o_q = q_r;
endmodule

// *** tb/asrc_sram_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Behavioural memory behind the pins
// ----------------------------------------
module asrc_sram_model
    import asrc_pkg::*;
#(
    parameter bit SLOW_GRADE = 1'b0
)
(
    // Pins from the host
    input wire asrc_pins_type i_pins,
    input wire logic [15:0] i_host_data,
    input wire logic [15:0] i_host_oe,
    // Resolved lines seen by the host
    output logic [15:0] o_bus,
    output logic o_corrected
);
    localparam int T_AA = SLOW_GRADE ? 55 : 45;
    localparam int T_MIN = SLOW_GRADE ? 45 : 35;
    logic [15:0] mem [0:255];
    logic err_flag [0:255];
    int viol = 0;
    realtime t_start;
    wire [7:0] a = i_pins.addr[7:0];
    wire [1:0] lane_n = {i_pins.upper_byte_en_n, i_pins.lower_byte_en_n};
    // Selection and operating modes
    wire sel = ~i_pins.select_primary_n & i_pins.select_secondary_hi;
    wire wr_act = sel & ~i_pins.write_en_n & (lane_n != 2'b11);
    wire rd_act = sel & ~i_pins.out_en_n & i_pins.write_en_n;
    wire #1 wr_old = wr_act;
    // Lane drive: late turn-on, release within the float time
    wire #(10, 18) hi_on = rd_act & ~lane_n[1];
    wire #(10, 18) lo_on = rd_act & ~lane_n[0];
    wire #(10, 18) flag_on = rd_act;
    // Stored word and flag settle one access time after the address
    wire [15:0] #(T_AA) rd_word = mem[a];
    wire #(T_AA) err_d = err_flag[a];
    wire [15:0] dev_on = {{8{hi_on}}, {8{lo_on}}};

    initial
    begin
        foreach (err_flag[i])
            err_flag[i] = 1'b0;
    end

    // Undriven lines show the inverse so stale values never pass
    always_comb
        for (int i = 0; i < 16; i++)
            o_bus[i] = i_host_oe[i] ? i_host_data[i] : (dev_on[i] ~^ rd_word[i]);
    assign o_corrected = flag_on ? err_d : ~err_d;

    // Lanes are written while the write overlap lasts
    always @*
        if (wr_act)
        begin
            if (!lane_n[1])
                mem[a][15:8] = i_host_data[15:8];
            if (!lane_n[0])
                mem[a][7:0] = i_host_data[7:0];
        end

    // Address and data must not move inside a write
    always @(i_pins.addr or i_host_data)
        if (wr_act && wr_old)
            viol++;
    always @(posedge wr_act)
        t_start = $realtime;
    // Write overlap must last the least write time; the power-up fall is no write
    always @(negedge wr_act)
        if (wr_old === 1'b1 && $realtime - t_start < T_MIN)
            viol++;
endmodule

// *** tb/test_async_sram_ecc_cycle_timing.sv ***
`timescale 1ns/1ns
`include "asrc_consts.svh"
// ----------------------------------------
// Bench for the static memory controller
// ----------------------------------------
module test_async_sram_ecc_cycle_timing
    import asrc_pkg::*;
;
    logic clk;
    logic rst;
    logic req_valid;
    asrc_req_type req;
    logic req_ready;
    logic rsp_valid;
    asrc_rsp_type rsp;
    asrc_pins_type pins;
    logic [15:0] bus;
    logic [15:0] hdata;
    logic [15:0] hoe;
    logic corrected;
    int err_total = 0;
    int samples_checked = 0;
    int since = 99;

    asrc_ctrl #(.SLOW_GRADE(1'b0)) i_dut (.i_clk(clk), .i_rst(rst),
        .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
        .o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_pins(pins), .i_data(bus),
        .o_data(hdata), .o_data_oe(hoe), .i_corrected(corrected));
    asrc_sram_model #(.SLOW_GRADE(1'b0)) i_mem (.i_pins(pins), .i_host_data(hdata),
        .i_host_oe(hoe), .o_bus(bus), .o_corrected(corrected));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One request: wait to be taken, then for a read the answer
    task automatic access(input logic wr, input logic [1:0] be, input logic [17:0] ad,
        input logic [15:0] d);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{write: wr, byte_en: be, addr: ad, wdata: d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (req_ready !== 1'b1 && n < 60);
        check("taken", req_ready, 1'b1);
        req_valid <= 1'b0;
        n = 0;
        if (!wr)
        begin
            do
            begin
                @(posedge clk);
                #1;
                n++;
            end
            while (rsp_valid !== 1'b1 && n < 40);
            // Pulse is seen just after the edge that ends the sample wait
            check("latency", n, `ASRC_RD_CYC_FAST);
        end
    endtask

    // Strobes are only ever given with the memory selected; takes are spaced
    always @(posedge clk)
    begin
        since <= since + 1;
        if (!rst && (!pins.out_en_n || !pins.write_en_n))
            check("select", {pins.select_primary_n, pins.select_secondary_hi}, 2'b01);
        if (req_valid && req_ready)
        begin
            check("gap", since >= `ASRC_RC_CYC_FAST, 1);
            since <= 1;
        end
    end

    task automatic t_full();
        access(1'b1, 2'b11, 18'h00010, 16'hA5C3);
        access(1'b0, 2'b11, 18'h00010, 16'h0000);
        check("rdata", rsp.rdata, 16'hA5C3);
        check("flag", rsp.corrected, 1'b0);
        $display("t_full done");
    endtask

    task automatic t_bytes();
        access(1'b1, 2'b11, 18'h00020, 16'h1234);
        access(1'b1, 2'b10, 18'h00020, 16'hABFF);
        access(1'b1, 2'b01, 18'h00020, 16'h00CD);
        access(1'b0, 2'b11, 18'h00020, 16'h0000);
        check("merge", rsp.rdata, 16'hABCD);
        access(1'b0, 2'b10, 18'h00020, 16'h0000);
        check("upper", rsp.rdata[15:8], 8'hAB);
        access(1'b0, 2'b01, 18'h00020, 16'h0000);
        check("lower", rsp.rdata[7:0], 8'hCD);
        $display("t_bytes done");
    endtask

    task automatic t_err();
        i_mem.err_flag[8'h30] = 1'b1;
        access(1'b1, 2'b11, 18'h00030, 16'h5555);
        access(1'b0, 2'b11, 18'h00030, 16'h0000);
        check("flag", rsp.corrected, 1'b1);
        check("rdata", rsp.rdata, 16'h5555);
        access(1'b0, 2'b11, 18'h00010, 16'h0000);
        check("flag", rsp.corrected, 1'b0);
        check("rdata", rsp.rdata, 16'hA5C3);
        $display("t_err done");
    endtask

    // Main sequence
    initial
    begin
        req_valid = 1'b0;
        req = '0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_full();
        t_bytes();
        t_err();
        check("timing", i_mem.viol, 0);
        report_and_stop();
    end

    // Watchdog
    initial
    begin
        #20000;
        err_total++;
        report_and_stop();
    end
endmodule
